// File: design/imucfg_regs.sv
`timescale 1ns/1ps
// How it works
// R1 - Self-test bit zero enables accelerometer self-test
// R2 - Self-test bit two selects excitation sign
// R3 - Self-test bit three selects deflection amplitude
// R4 - Gyro axis status register is read-only
// R5 - Protocol select bit forces SPI in autoconfig
// R6 - Watchdog period 1.25 ms or 40 ms
// R7 - Watchdog on data pin when enabled, I2C
// R8 - Accel offset apply bit adds offsets
// R9 - Three 8-bit accelerometer offset registers
// R10 - Ten-bit gyro offsets, shared high bits
// R11 - Gyro offset apply bit adds offsets
// R12 - Gyro gain compensation enable bit
// R13 - Advanced power save bit, reset 0x03
// R14 - FIFO read in low power enable
// R15 - Sensor power enable bits, reset zero
// R16 - Command register always reads zero
// R17 - Commands 0x02 and 0x03 pulse gyro ops
// R18 - Commands 0xa0 and 0xb0 program, flush
// R19 - Command 0xb6 restores register defaults, not the SPI lock
// R20 - I2C after reset, SPI4 or SPI3 later
// R21 - Secondary is aux controller or OIS target
// R22 - Aux mode reads external sensor autonomously
// R23 - OIS controller drives, device is target
// R24 - Serial out pin sets I2C address bit
// R25 - Chip select rise switches to SPI
// R26 - Aux enable wins over OIS enable
// R27 - Unknown command codes are ignored
module imucfg_regs
  import imucfg_pkg::*;
#(
  parameter int WDT_SHORT = WDT_SHORT_CYC,
  parameter int WDT_LONG = WDT_LONG_CYC,
  parameter int SPI_SWITCH = SPI_SWITCH_CYC
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  // Register access from the serial front end
  input wire imucfg_req_t i_req,
  output logic [7:0] o_rdata,
  // Status inputs
  input wire logic [3:0] i_gyro_test_status,
  input wire logic i_spi3_sel,
  input wire logic i_aux_sel,
  input wire logic i_ois_sel,
  // Pins
  input wire logic i_chip_select_pin,
  input wire logic i_serial_out_pin,
  input wire logic i_sda_pin,
  // Configuration outputs
  output logic o_accel_test_en,
  output logic o_accel_test_positive,
  output logic o_accel_test_high,
  output logic o_accel_off_apply,
  output logic [23:0] o_accel_offsets,
  output logic [29:0] o_gyro_offsets,
  output logic o_gyro_off_apply,
  output logic o_gyro_gain_en,
  output logic o_adv_power_save,
  output logic o_fifo_lp_read_en,
  output logic o_fast_power_up,
  output logic [3:0] o_power_enables,
  // Commands and interface state
  output imucfg_cmd_t o_cmd,
  output imucfg_iface_t o_iface_mode,
  output imucfg_sec_t o_secondary_mode,
  output logic [6:0] o_i2c_target_addr,
  output logic o_wdt_timeout
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  imucfg_state_t st_r;
  imucfg_state_t st_nxt;

  function automatic logic [7:0] wmask(input logic [7:0] v, input logic [7:0] m);
    wmask = v & m;
  endfunction : wmask

  function automatic imucfg_state_t defaults(input imucfg_state_t s);
    imucfg_state_t d;
    d = s;
    d.self_test = RST_ZERO;
    d.nonvolatile_iface_conf = RST_ZERO;
    d.acc_off_x = RST_ZERO;
    d.acc_off_y = RST_ZERO;
    d.acc_off_z = RST_ZERO;
    d.gyr_off_x = RST_ZERO;
    d.gyr_off_y = RST_ZERO;
    d.gyr_off_z = RST_ZERO;
    d.gyr_off_hi = RST_ZERO;
    d.power_saving_conf = RST_POWER_SAVING_CONF; // R13
    d.pwr_en = RST_ZERO; // R15
    defaults = d;
  endfunction : defaults

  logic wdt_active;
  logic [22:0] wdt_limit;

  always_comb begin
    st_nxt = st_r;
    st_nxt.cmd = '0;
    wdt_active = st_r.nonvolatile_iface_conf[NV_WDT_EN_BIT] && !st_r.spi_locked && !st_r.nonvolatile_iface_conf[NV_SPI_EN_BIT]; // R7
    wdt_limit = st_r.nonvolatile_iface_conf[NV_WDT_SEL_BIT] ? 23'(WDT_LONG - 1) : 23'(WDT_SHORT - 1); // R6
    // Pin synchronisers
    st_nxt.cs_q1 = i_chip_select_pin;
    st_nxt.cs_q2 = st_r.cs_q1;
    st_nxt.cs_q3 = st_r.cs_q2;
    st_nxt.sda_q1 = i_sda_pin;
    st_nxt.sda_q2 = st_r.sda_q1;
    st_nxt.sda_q3 = st_r.sda_q2;
    // Address strap caught once after reset release
    if (!st_r.strap_taken) begin
      st_nxt.strap_taken = 1'b1;
      st_nxt.addr_bit = i_serial_out_pin; // R24
    end
    // Chip select rising edge starts the SPI switch delay
    if (!st_r.spi_locked) begin
      if (st_r.cs_q2 && !st_r.cs_q3 && !st_r.spi_pending) begin
        st_nxt.spi_pending = 1'b1; // R25
        st_nxt.spi_cnt = '0;
      end else if (st_r.spi_pending) begin
        if (st_r.spi_cnt == 16'(SPI_SWITCH - 1)) begin
          st_nxt.spi_locked = 1'b1; // R25
          st_nxt.spi_pending = 1'b0;
        end else begin
          st_nxt.spi_cnt = st_r.spi_cnt + 16'h0001;
        end
      end
    end
    // Watchdog: data line held low too long
    st_nxt.wdt_fire = 1'b0;
    if (!wdt_active || st_r.sda_q2) begin
      st_nxt.wdt_cnt = '0;
    end else if (st_r.wdt_cnt >= wdt_limit) begin
      st_nxt.wdt_fire = 1'b1; // R7
      st_nxt.wdt_cnt = '0;
    end else begin
      st_nxt.wdt_cnt = st_r.wdt_cnt + 23'h000001;
    end
    // Register writes
    if (i_req.wr) begin
      case (i_req.addr)
        ADDR_ACCEL_SELF_TEST_CTRL: st_nxt.self_test = wmask(i_req.wdata, MASK_SELF_TEST); // R1
        ADDR_NONVOLATILE_IFACE_CONF: st_nxt.nonvolatile_iface_conf = wmask(i_req.wdata, MASK_NONVOLATILE_IFACE_CONF); // R5
        ADDR_ACCEL_OFFSET_X: st_nxt.acc_off_x = i_req.wdata; // R9
        ADDR_ACCEL_OFFSET_Y: st_nxt.acc_off_y = i_req.wdata; // R9
        ADDR_ACCEL_OFFSET_Z: st_nxt.acc_off_z = i_req.wdata; // R9
        ADDR_GYRO_OFFSET_X_LOW: st_nxt.gyr_off_x = i_req.wdata; // R10
        ADDR_GYRO_OFFSET_Y_LOW: st_nxt.gyr_off_y = i_req.wdata; // R10
        ADDR_GYRO_OFFSET_Z_LOW: st_nxt.gyr_off_z = i_req.wdata; // R10
        ADDR_GYRO_OFFSET_HIGH_ENABLES: st_nxt.gyr_off_hi = i_req.wdata; // R10
        ADDR_POWER_SAVING_CONF: st_nxt.power_saving_conf = wmask(i_req.wdata, MASK_POWER_CONF); // R13
        ADDR_SENSOR_POWER_ENABLES: st_nxt.pwr_en = wmask(i_req.wdata, MASK_POWER_EN); // R15
        ADDR_COMMAND_PORT: begin
          case (i_req.wdata)
            CMD_GYRO_TRIGGER: st_nxt.cmd.gyro_trigger = 1'b1; // R17
            CMD_GAIN_APPLY: st_nxt.cmd.gain_apply = 1'b1; // R17
            CMD_NVM_PROGRAM: st_nxt.cmd.nvm_program = 1'b1; // R18
            CMD_FIFO_FLUSH: st_nxt.cmd.fifo_flush = 1'b1; // R18
            CMD_SOFT_RESET: begin
              st_nxt.cmd.soft_reset = 1'b1; // R19
              st_nxt = defaults(st_nxt);
            end
            default: ; // R27
          endcase
        end
        default: ; // R4
      endcase
    end
    // Register reads
    if (i_req.rd) begin
      case (i_req.addr)
        ADDR_ACCEL_SELF_TEST_CTRL: st_nxt.rdata = st_r.self_test;
        ADDR_GYRO_AXIS_TEST_STATUS: st_nxt.rdata = {4'h0, i_gyro_test_status}; // R4
        ADDR_NONVOLATILE_IFACE_CONF: st_nxt.rdata = st_r.nonvolatile_iface_conf;
        ADDR_ACCEL_OFFSET_X: st_nxt.rdata = st_r.acc_off_x;
        ADDR_ACCEL_OFFSET_Y: st_nxt.rdata = st_r.acc_off_y;
        ADDR_ACCEL_OFFSET_Z: st_nxt.rdata = st_r.acc_off_z;
        ADDR_GYRO_OFFSET_X_LOW: st_nxt.rdata = st_r.gyr_off_x;
        ADDR_GYRO_OFFSET_Y_LOW: st_nxt.rdata = st_r.gyr_off_y;
        ADDR_GYRO_OFFSET_Z_LOW: st_nxt.rdata = st_r.gyr_off_z;
        ADDR_GYRO_OFFSET_HIGH_ENABLES: st_nxt.rdata = st_r.gyr_off_hi;
        ADDR_POWER_SAVING_CONF: st_nxt.rdata = st_r.power_saving_conf;
        ADDR_SENSOR_POWER_ENABLES: st_nxt.rdata = st_r.pwr_en;
        ADDR_COMMAND_PORT: st_nxt.rdata = 8'h00; // R16
        default: st_nxt.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      st_r <= '0;
      st_r.power_saving_conf <= RST_POWER_SAVING_CONF; // R13
      // Pins idle high, so no false chip select edge after reset
      st_r.cs_q1 <= 1'b1;
      st_r.cs_q2 <= 1'b1;
      st_r.cs_q3 <= 1'b1;
      st_r.sda_q1 <= 1'b1;
      st_r.sda_q2 <= 1'b1;
      st_r.sda_q3 <= 1'b1;
    end else if (i_clk_en) begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_rdata = st_r.rdata;
  assign o_accel_test_en = st_r.self_test[ST_EN_BIT]; // R1
  assign o_accel_test_positive = st_r.self_test[ST_SIGN_BIT]; // R2
  assign o_accel_test_high = st_r.self_test[ST_AMP_BIT]; // R3
  assign o_accel_off_apply = st_r.nonvolatile_iface_conf[NV_ACC_OFF_EN_BIT]; // R8
  assign o_accel_offsets = {st_r.acc_off_z, st_r.acc_off_y, st_r.acc_off_x}; // R9
  assign o_gyro_offsets = {st_r.gyr_off_hi[GO_Z_HI_POS+:2], st_r.gyr_off_z,
                           st_r.gyr_off_hi[GO_Y_HI_POS+:2], st_r.gyr_off_y,
                           st_r.gyr_off_hi[GO_X_HI_POS+:2], st_r.gyr_off_x}; // R10
  assign o_gyro_off_apply = st_r.gyr_off_hi[GO_OFF_EN_BIT]; // R11
  assign o_gyro_gain_en = st_r.gyr_off_hi[GO_GAIN_EN_BIT]; // R12
  assign o_adv_power_save = st_r.power_saving_conf[PS_ADV_BIT]; // R13
  assign o_fifo_lp_read_en = st_r.power_saving_conf[PS_FIFO_WAKE_BIT]; // R14
  assign o_fast_power_up = st_r.power_saving_conf[PS_FUP_BIT];
  assign o_power_enables = st_r.pwr_en[3:0]; // R15
  assign o_cmd = st_r.cmd;
  assign o_wdt_timeout = st_r.wdt_fire;
  assign o_i2c_target_addr = {I2C_TARGET_BASE[6:1], st_r.addr_bit}; // R24

  always_comb begin
    if (st_r.spi_locked || st_r.nonvolatile_iface_conf[NV_SPI_EN_BIT]) begin // R5
      o_iface_mode = i_spi3_sel ? IF_SPI3 : IF_SPI4; // R20
    end else begin
      o_iface_mode = IF_I2C; // R20
    end
    if (i_aux_sel) begin
      o_secondary_mode = SEC_AUX; // R22 R26
    end else if (i_ois_sel) begin
      o_secondary_mode = SEC_OIS; // R23
    end else begin
      o_secondary_mode = SEC_OFF; // R21
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  cmd_read_zero_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // R16
    i_clk_en && i_req.rd && i_req.addr == ADDR_COMMAND_PORT |=> o_rdata == 8'h00)
    else $error("command port read not zero");
  soft_reset_def_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // R19
    o_cmd.soft_reset |-> o_power_enables == 4'h0 && st_r.power_saving_conf == RST_POWER_SAVING_CONF)
    else $error("soft reset left settings");
  unknown_cmd_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // R27
    i_clk_en && i_req.wr && i_req.addr == ADDR_COMMAND_PORT && i_req.wdata == 8'h55
    |=> o_cmd == '0)
    else $error("unknown command acted");
  self_test_wr_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // R1
    i_clk_en && i_req.wr && i_req.addr == ADDR_ACCEL_SELF_TEST_CTRL
    |=> o_accel_test_en == $past(i_req.wdata[0]))
    else $error("self-test enable not stored");
  spi_force_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // R5
    st_r.nonvolatile_iface_conf[NV_SPI_EN_BIT] |-> o_iface_mode != IF_I2C)
    else $error("protocol select ignored");
  aux_prio_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // R26
    i_aux_sel && i_ois_sel |-> o_secondary_mode == SEC_AUX)
    else $error("aux priority lost");
  flush_pulse_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // R18
    i_clk_en && i_req.wr && i_req.addr == ADDR_COMMAND_PORT && i_req.wdata == CMD_FIFO_FLUSH
    |=> o_cmd.fifo_flush ##1 (!o_cmd.fifo_flush || $past(i_req.wr)))
    else $error("flush pulse wrong");
  wdt_idle_a: assert property (@(posedge i_core_clk) disable iff (i_sys_rst) // R7
    !st_r.nonvolatile_iface_conf[NV_WDT_EN_BIT] |-> st_r.wdt_cnt == '0 || $past(st_r.nonvolatile_iface_conf[NV_WDT_EN_BIT]))
    else $error("watchdog runs while disabled");

endmodule : imucfg_regs

// File: pkg/imucfg_pkg.sv
package imucfg_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_ACCEL_SELF_TEST_CTRL = 8'h6d;
  localparam logic [7:0] ADDR_GYRO_AXIS_TEST_STATUS = 8'h6e;
  localparam logic [7:0] ADDR_NONVOLATILE_IFACE_CONF = 8'h70;
  localparam logic [7:0] ADDR_ACCEL_OFFSET_X = 8'h71;
  localparam logic [7:0] ADDR_ACCEL_OFFSET_Y = 8'h72;
  localparam logic [7:0] ADDR_ACCEL_OFFSET_Z = 8'h73;
  localparam logic [7:0] ADDR_GYRO_OFFSET_X_LOW = 8'h74;
  localparam logic [7:0] ADDR_GYRO_OFFSET_Y_LOW = 8'h75;
  localparam logic [7:0] ADDR_GYRO_OFFSET_Z_LOW = 8'h76;
  localparam logic [7:0] ADDR_GYRO_OFFSET_HIGH_ENABLES = 8'h77;
  localparam logic [7:0] ADDR_POWER_SAVING_CONF = 8'h7c;
  localparam logic [7:0] ADDR_SENSOR_POWER_ENABLES = 8'h7d;
  localparam logic [7:0] ADDR_COMMAND_PORT = 8'h7e;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_POWER_SAVING_CONF = 8'h03;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ST_EN_BIT = 0;
  localparam int ST_SIGN_BIT = 2;
  localparam int ST_AMP_BIT = 3;
  localparam int NV_SPI_EN_BIT = 0;
  localparam int NV_WDT_SEL_BIT = 1;
  localparam int NV_WDT_EN_BIT = 2;
  localparam int NV_ACC_OFF_EN_BIT = 3;
  localparam int GO_X_HI_POS = 0;
  localparam int GO_Y_HI_POS = 2;
  localparam int GO_Z_HI_POS = 4;
  localparam int GO_OFF_EN_BIT = 6;
  localparam int GO_GAIN_EN_BIT = 7;
  localparam int PS_ADV_BIT = 0;
  localparam int PS_FIFO_WAKE_BIT = 1;
  localparam int PS_FUP_BIT = 2;
  localparam int PE_AUX_BIT = 0;
  localparam int PE_GYR_BIT = 1;
  localparam int PE_ACC_BIT = 2;
  localparam int PE_TEMP_BIT = 3;

  // Writable bit masks
  localparam logic [7:0] MASK_SELF_TEST = 8'h0d;
  localparam logic [7:0] MASK_NONVOLATILE_IFACE_CONF = 8'h0f;
  localparam logic [7:0] MASK_POWER_CONF = 8'h07;
  localparam logic [7:0] MASK_POWER_EN = 8'h0f;

  // ----------------------------------------------------------------
  // Commands
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_GYRO_TRIGGER = 8'h02;
  localparam logic [7:0] CMD_GAIN_APPLY = 8'h03;
  localparam logic [7:0] CMD_NVM_PROGRAM = 8'ha0;
  localparam logic [7:0] CMD_FIFO_FLUSH = 8'hb0;
  localparam logic [7:0] CMD_SOFT_RESET = 8'hb6;

  // ----------------------------------------------------------------
  // Target addresses and timing
  // ----------------------------------------------------------------
  localparam logic [6:0] I2C_TARGET_BASE = 7'h68;
  localparam int CLK_MHZ = 125;
  localparam int WDT_SHORT_US_X100 = 125;
  localparam int WDT_LONG_MS = 40;
  localparam int SPI_SWITCH_US = 200;
  localparam int WDT_SHORT_CYC = (WDT_SHORT_US_X100 * 10 * CLK_MHZ) / 1;
  localparam int WDT_LONG_CYC = WDT_LONG_MS * 1000 * CLK_MHZ;
  localparam int SPI_SWITCH_CYC = SPI_SWITCH_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {IF_I2C, IF_SPI4, IF_SPI3} imucfg_iface_t;
  typedef enum logic [1:0] {SEC_OFF, SEC_AUX, SEC_OIS} imucfg_sec_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } imucfg_req_t;

  typedef struct packed {
    logic gyro_trigger;
    logic gain_apply;
    logic nvm_program;
    logic fifo_flush;
    logic soft_reset;
  } imucfg_cmd_t;

  typedef struct packed {
    logic [7:0] self_test;
    logic [7:0] nonvolatile_iface_conf;
    logic [7:0] acc_off_x;
    logic [7:0] acc_off_y;
    logic [7:0] acc_off_z;
    logic [7:0] gyr_off_x;
    logic [7:0] gyr_off_y;
    logic [7:0] gyr_off_z;
    logic [7:0] gyr_off_hi;
    logic [7:0] power_saving_conf;
    logic [7:0] pwr_en;
    logic [7:0] rdata;
    imucfg_cmd_t cmd;
    logic cs_q1;
    logic cs_q2;
    logic cs_q3;
    logic sda_q1;
    logic sda_q2;
    logic sda_q3;
    logic spi_pending;
    logic [15:0] spi_cnt;
    logic spi_locked;
    logic [22:0] wdt_cnt;
    logic wdt_fire;
    logic strap_taken;
    logic addr_bit;
  } imucfg_state_t;

endpackage : imucfg_pkg

// File: tb/imucfg_host.sv
`timescale 1ns/1ps
module imucfg_host
  import imucfg_pkg::*;
(
  // Clock and read data
  input wire logic i_core_clk,
  input wire logic [7:0] i_rdata,
  // Request to the block
  output imucfg_req_t o_req
);
  initial o_req = '0;

  // Released fields show inverted leftovers, never stale values
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    #1 o_req = '{1'b1, 1'b0, a, d};
    @(posedge i_core_clk);
    #1 o_req = '{1'b0, 1'b0, ~a, ~d};
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_core_clk);
    #1 o_req = '{1'b0, 1'b1, a, 8'h00};
    @(posedge i_core_clk);
    #1 o_req = '{1'b0, 1'b0, ~a, 8'hff};
    @(posedge i_core_clk);
    #1 d = i_rdata;
  endtask : rd
endmodule : imucfg_host

// File: tb/testbench.sv
`timescale 1ns/1ps
module testbench
  import imucfg_pkg::*;
();
  localparam int WS = 20;
  localparam int WL = 40;
  localparam int SW = 10;
  logic clk = 0, rst = 1, cen = 1, spi3 = 0, aux = 0, ois = 0;
  logic chip_select_pin = 1, so = 1, sda = 1;
  logic [3:0] gts = 4'ha;
  imucfg_req_t req;
  logic [7:0] rdata;
  logic ten, tpos, thi, aoff, gapp, ggain, adv, fifo, fup, wdt;
  logic [23:0] aoffs;
  logic [29:0] goffs;
  logic [3:0] pe;
  logic [6:0] taddr;
  imucfg_cmd_t cmd;
  imucfg_iface_t mode;
  imucfg_sec_t sec;
  int fail_count = 0;
  int cmp_count = 0;
  int pc [6];
  logic [5:0] cv;
  logic [7:0] ra [12] = '{8'h6d, 8'h71, 8'h72, 8'h73, 8'h74, 8'h75, 8'h76, 8'h77,
    8'h7c, 8'h7d, 8'h6e, 8'h7f};
  logic [7:0] wv [12] = '{8'hff, 8'h5a, 8'ha5, 8'h3c, 8'h11, 8'h22, 8'h33, 8'he4,
    8'h04, 8'hff, 8'hff, 8'hff};
  logic [7:0] rv [12] = '{MASK_SELF_TEST, 8'h5a, 8'ha5, 8'h3c, 8'h11, 8'h22, 8'h33,
    8'he4, 8'h04, MASK_POWER_EN, 8'h0a, 8'h00};

  assign cv = {cmd, wdt};
  always #4 clk = ~clk;
  always @(posedge clk) for (int i = 0; i < 6; i++) if (cv[i] === 1'b1) pc[i]++;

  imucfg_regs #(.WDT_SHORT(WS), .WDT_LONG(WL), .SPI_SWITCH(SW)) imucfg_regs_inst (
    .i_core_clk(clk), .i_sys_rst(rst), .i_clk_en(cen), .i_req(req), .o_rdata(rdata),
    .i_gyro_test_status(gts), .i_spi3_sel(spi3), .i_aux_sel(aux), .i_ois_sel(ois),
    .i_chip_select_pin(chip_select_pin), .i_serial_out_pin(so), .i_sda_pin(sda),
    .o_accel_test_en(ten), .o_accel_test_positive(tpos), .o_accel_test_high(thi),
    .o_accel_off_apply(aoff), .o_accel_offsets(aoffs), .o_gyro_offsets(goffs),
    .o_gyro_off_apply(gapp), .o_gyro_gain_en(ggain), .o_adv_power_save(adv),
    .o_fifo_lp_read_en(fifo), .o_fast_power_up(fup), .o_power_enables(pe),
    .o_cmd(cmd), .o_iface_mode(mode), .o_secondary_mode(sec),
    .o_i2c_target_addr(taddr), .o_wdt_timeout(wdt));

  imucfg_host imucfg_host_inst (.i_core_clk(clk), .i_rdata(rdata), .o_req(req));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic print_verdict();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    imucfg_host_inst.rd(a, d);
    chk($sformatf("reg %h", a), {24'h0, e}, {24'h0, d});
  endtask : rchk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic do_rst(input logic s);
    @(posedge clk);
    #1 so = s;
    rst = 1;
    repeat (6) @(posedge clk);
    #1 rst = 0;
    cyc(2);
  endtask : do_rst

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset_vals();
    for (int i = 0; i < 12; i++) begin
      rchk(ra[i], ra[i] == 8'h6e ? 8'h0a : ra[i] == 8'h7c ? 8'h03 : 8'h00);
    end
    rchk(8'h7e, 8'h00);
    chk("addr", 32'h69, taddr);
    chk("mode", IF_I2C, mode);
    chk("adv fifo", 2'b11, {adv, fifo});
  endtask : t_reset_vals

  task automatic t_rw();
    for (int i = 0; i < 12; i++) imucfg_host_inst.wr(ra[i], wv[i]);
    for (int i = 0; i < 12; i++) rchk(ra[i], rv[i]);
    chk("self test", 3'b111, {ten, tpos, thi});
    chk("acc offs", 24'h3ca55a, aoffs);
    chk("gyr offs", {10'h233, 10'h122, 10'h011}, goffs);
    chk("gyr en", 2'b11, {gapp, ggain});
    chk("pwr", 3'b001, {adv, fifo, fup});
    chk("pwr en", 4'hf, pe);
    imucfg_host_inst.wr(8'h6d, 8'h08);
    chk("self test", 3'b001, {ten, tpos, thi});
  endtask : t_rw

  task automatic t_cen();
    cen = 0;
    imucfg_host_inst.wr(8'h7d, 8'h00);
    cen = 1;
    rchk(8'h7d, 8'h0f);
  endtask : t_cen

  task automatic t_nv();
    imucfg_host_inst.wr(8'h70, 8'h08);
    chk("acc apply", 1, aoff);
    chk("mode", IF_I2C, mode);
    imucfg_host_inst.wr(8'h70, 8'h01);
    chk("mode", IF_SPI4, mode);
    spi3 = 1;
    cyc(1);
    chk("mode", IF_SPI3, mode);
    spi3 = 0;
    imucfg_host_inst.wr(8'h70, 8'h00);
    chk("mode", IF_I2C, mode);
  endtask : t_nv

  task automatic t_sec();
    for (int i = 0; i < 4; i++) begin
      {aux, ois} = i[1:0];
      cyc(1);
      chk("sec", aux ? SEC_AUX : ois ? SEC_OIS : SEC_OFF, sec);
    end
  endtask : t_sec

  task automatic t_wdt_off();
    imucfg_host_inst.wr(8'h70, 8'h02);
    pc[0] = 0;
    sda = 0;
    cyc(60);
    chk("wdt off", 0, pc[0]);
    sda = 1;
  endtask : t_wdt_off

  task automatic t_wdt(input logic sel, input int lim);
    int n;
    n = 0;
    imucfg_host_inst.wr(8'h70, {5'h0, 1'b1, sel, 1'b0});
    sda = 0;
    while (wdt !== 1'b1) begin
      cyc(1);
      n++;
      if (n > 200) begin
        fail_count++;
        print_verdict();
      end
    end
    chk("wdt time", 1, n >= lim && n <= lim + 8);
    sda = 1;
    imucfg_host_inst.wr(8'h70, 8'h00);
  endtask : t_wdt

  task automatic t_cmd();
    logic [7:0] cd [6] = '{8'h55, CMD_SOFT_RESET, CMD_FIFO_FLUSH, CMD_NVM_PROGRAM,
      CMD_GAIN_APPLY, CMD_GYRO_TRIGGER};
    int i;
    imucfg_host_inst.wr(8'h7c, 8'h00);
    for (int k = 0; k < 6; k++) begin
      i = k == 0 ? 0 : 6 - k;
      foreach (pc[j]) pc[j] = 0;
      imucfg_host_inst.wr(8'h7e, cd[i]);
      cyc(3);
      for (int j = 0; j < 6; j++) chk("pulses", j == i && j > 0, pc[j]);
      if (k == 0) rchk(8'h7c, 8'h00);
      rchk(8'h7e, 8'h00);
    end
    rchk(8'h71, 8'h00);
    rchk(8'h7c, 8'h03);
  endtask : t_cmd

  task automatic t_cs();
    int n;
    n = 0;
    chip_select_pin = 0;
    cyc(3);
    chip_select_pin = 1;
    while (mode === IF_I2C) begin
      cyc(1);
      n++;
      if (n > 100) begin
        fail_count++;
        print_verdict();
      end
    end
    chk("cs time", 1, n >= SW && n <= SW + 8);
    chk("mode", IF_SPI4, mode);
    imucfg_host_inst.wr(8'h7e, CMD_SOFT_RESET);
    cyc(2);
    chk("mode", IF_SPI4, mode);
    do_rst(1'b0);
    chk("mode", IF_I2C, mode);
    chk("addr", 32'h68, taddr);
  endtask : t_cs

  initial begin
    do_rst(1'b1);
    t_reset_vals();
    t_rw();
    t_cen();
    t_nv();
    t_sec();
    t_wdt_off();
    t_wdt(1'b0, WS);
    t_wdt(1'b1, WL);
    t_cmd();
    t_cs();
    print_verdict();
  end
endmodule : testbench
